// ===== operand_addr_pkg.sv
// Purpose: Shared constants and types for the operand address unit.
// Assumes: 16-bit words, eight general registers, byte-addressed memory.
// Notes:   Field positions follow the six-bit mode/register operand field.
package operand_addr_pkg;

    // ****************************************************************
    // Word and field layout
    // ****************************************************************
    localparam int WORD_W   = 16;
    localparam int REG_W    = 3;
    localparam int NUM_REGS = 8;
    localparam int REG_LSB  = 0;
    localparam int DEF_BIT  = 3;
    localparam int MODE_LSB = 4;
    localparam int DST_LSB  = 0;
    localparam int SRC_LSB  = 6;
    localparam int BYTE_BIT = 15;

    // ****************************************************************
    // Special registers, steps and reset values
    // ****************************************************************
    localparam logic [2:0]  STACK_IDX  = 3'h6;
    localparam logic [2:0]  IP_IDX     = 3'h7;
    localparam logic [15:0] WORD_STEP  = 16'h0002;
    localparam logic [15:0] BYTE_STEP  = 16'h0001;
    localparam logic [15:0] WORD_RST   = 16'h0000;
    localparam logic [1:0]  BE_LOW     = 2'h1;
    localparam logic [1:0]  BE_BOTH    = 2'h3;

    // ****************************************************************
    // Addressing modes, three-bit form of the field's mode bits
    // ****************************************************************
    localparam logic [2:0] MODE_REG      = 3'h0;
    localparam logic [2:0] MODE_REG_DEF  = 3'h1;
    localparam logic [2:0] MODE_AINC     = 3'h2;
    localparam logic [2:0] MODE_AINC_DEF = 3'h3;
    localparam logic [2:0] MODE_ADEC     = 3'h4;
    localparam logic [2:0] MODE_ADEC_DEF = 3'h5;
    localparam logic [2:0] MODE_IDX      = 3'h6;
    localparam logic [2:0] MODE_IDX_DEF  = 3'h7;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_RD      = 4'h1,
        ST_EVAL    = 4'h2,
        ST_RDPC    = 4'h3,
        ST_PCV     = 4'h4,
        ST_XFETCH  = 4'h5,
        ST_INDIR   = 4'h6,
        ST_OPDONE  = 4'h7,
        ST_WAITRES = 4'h8,
        ST_WRRES   = 4'h9,
        ST_FINISH  = 4'ha
    } state_t;

endpackage

// ===== operand_regfile.sv
// Purpose: Eight-word general register store with a registered read port.
// Assumes: One read and one write per cycle; byte enables on the write.
// Notes:   A write and a read of the same word in one cycle return old data.
module operand_regfile #(
    parameter int W = 16,
    parameter int N = 8
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Read port
    input  wire logic [$clog2(N)-1:0] raddr,
    output logic      [W-1:0]         rdata,
    // Write port
    input  wire logic                 we,
    input  wire logic [$clog2(N)-1:0] waddr,
    input  wire logic [W-1:0]         wdata,
    input  wire logic [W/8-1:0]       wbe
);

    typedef struct packed {
        logic [N-1:0][W-1:0] mem;
        logic [W-1:0]        rd;
    } rf_state_t;

    rf_state_t s_ff;
    rf_state_t nxt_s;

    always_comb begin
        nxt_s    = s_ff;
        nxt_s.rd = s_ff.mem[raddr];
        for (int b = 0; b < W / 8; b++) begin
            if (we && wbe[b]) begin
                nxt_s.mem[waddr][b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rdata = s_ff.rd;

endmodule

// ===== operand_step_calc.sv
// Purpose: Pointer step amount for autoincrement and autodecrement.
// Assumes: Mode is the three mode bits of the operand field.
// Notes:   Purely combinational.
module operand_step_calc (
    // Operand description
    input  wire logic [2:0]  mode,
    input  wire logic [2:0]  reg_idx,
    input  wire logic        byte_op,
    // Step amount
    output logic      [15:0] step
);

    always_comb begin
        step = operand_addr_pkg::WORD_STEP;
        // Deferred forms always walk a table of word addresses.
        if (byte_op && (mode == operand_addr_pkg::MODE_AINC ||
                        mode == operand_addr_pkg::MODE_ADEC) &&
            reg_idx != operand_addr_pkg::STACK_IDX &&
            reg_idx != operand_addr_pkg::IP_IDX) begin
            step = operand_addr_pkg::BYTE_STEP;
        end
    end

endmodule

// ===== operand_address_modes.sv
// Purpose: Resolves source and destination operand locations of one instruction.
// Assumes: Instruction word already fetched; instruction pointer is register 7.
// Notes:   Memory accesses are word reads plus one result write, held until ack.
//
// How it works
// - Autoincrement uses register, then steps one for bytes, two otherwise or for 6/7.
// - Autodecrement steps the register down first, then uses it as address.
// - Byte result into a register changes only its low eight bits.
// - Index mode adds the following word to the register, changing neither.
// - Register deferred uses register contents as address, register unchanged.
// - Autoincrement deferred reads address word, then adds two to register.
// - Autodecrement deferred subtracts two first, then reads the address word.
// - Index deferred reads the address word at register plus index.
// - Every word fetched through the instruction pointer advances it by two.
// - Immediate: operand is the word after the instruction, pointer advances past.
// - Absolute: following word is the address, pointer advances past it.
// - Relative: following word plus advanced pointer is the address.
// - Relative deferred: following word plus pointer locates the address word.
// - Source and destination resolve separately; result goes to destination only.
// - Low three bits pick register, bits 5:4 mode, bit 3 deferral.
// - Instruction bit 15 set means a byte operation.
module operand_address_modes (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Instruction request
    input  wire logic        start,
    input  wire logic [15:0] instr,
    input  wire logic        two_op,
    output logic             busy,
    // Resolved operand locations
    output logic             resolved,
    output logic [15:0]      src_loc,
    output logic             src_in_reg,
    output logic [15:0]      dst_loc,
    output logic             dst_in_reg,
    output logic             byte_op,
    // Result from execution
    input  wire logic        result_valid,
    input  wire logic [15:0] result_data,
    output logic             done,
    // Register loading while idle
    input  wire logic        load_en,
    input  wire logic [2:0]  load_idx,
    input  wire logic [15:0] load_data,
    // Memory interface
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_byte,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata
);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        operand_addr_pkg::state_t state;
        logic                     is_src;
        logic                     byte_op;
        logic                     two_op;
        logic [5:0]               src_fld;
        logic [5:0]               dst_fld;
        logic [15:0]              ptr;
        logic [15:0]              ip_word;
        logic [15:0]              loc;
        logic                     in_reg;
        logic                     wr_en;
        logic [2:0]               wr_idx;
        logic [15:0]              wr_data;
        logic [1:0]               wr_be;
        logic                     mem_req;
        logic                     mem_we;
        logic                     mem_byte;
        logic [15:0]              mem_addr;
        logic [15:0]              mem_wdata;
        logic [15:0]              src_loc;
        logic                     src_in_reg;
        logic [15:0]              dst_loc;
        logic                     dst_in_reg;
        logic                     busy;
        logic                     resolved;
        logic                     done;
    } ctl_t;

    ctl_t s_ff;
    ctl_t nxt_s;

    logic [5:0]  cur_fld;
    logic [2:0]  cur_mode;
    logic [2:0]  cur_reg;
    logic [15:0] step;
    logic [2:0]  rf_raddr;
    logic [15:0] rf_rdata;
    logic        rf_we;
    logic [2:0]  rf_waddr;
    logic [15:0] rf_wdata;
    logic [1:0]  rf_wbe;
    logic        idle;

    // ****************************************************************
    // Field decode
    // ****************************************************************
    assign cur_fld  = s_ff.is_src ? s_ff.src_fld : s_ff.dst_fld;
    assign cur_reg  = cur_fld[operand_addr_pkg::REG_LSB +: 3];
    assign cur_mode = {cur_fld[operand_addr_pkg::MODE_LSB +: 2],
                       cur_fld[operand_addr_pkg::DEF_BIT]};
    assign idle     = (s_ff.state == operand_addr_pkg::ST_IDLE);

    operand_step_calc u_step (
        .mode    (cur_mode),
        .reg_idx (cur_reg),
        .byte_op (s_ff.byte_op),
        .step    (step)
    );

    // ****************************************************************
    // Register store
    // ****************************************************************
    // Loading shares the write port and is taken only while idle, so it can
    // never race a pointer update of a running instruction.
    assign rf_we    = s_ff.wr_en | (idle & load_en);
    assign rf_waddr = s_ff.wr_en ? s_ff.wr_idx  : load_idx;
    assign rf_wdata = s_ff.wr_en ? s_ff.wr_data : load_data;
    assign rf_wbe   = s_ff.wr_en ? s_ff.wr_be   : operand_addr_pkg::BE_BOTH;
    assign rf_raddr = (s_ff.state == operand_addr_pkg::ST_RDPC) ?
                      operand_addr_pkg::IP_IDX : cur_reg;

    operand_regfile #(
        .W (operand_addr_pkg::WORD_W),
        .N (operand_addr_pkg::NUM_REGS)
    ) u_regs (
        .clk   (clk),
        .rstn  (rstn),
        .raddr (rf_raddr),
        .rdata (rf_rdata),
        .we    (rf_we),
        .waddr (rf_waddr),
        .wdata (rf_wdata),
        .wbe   (rf_wbe)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    function automatic ctl_t issue_read(input ctl_t c, input logic [15:0] addr);
        issue_read          = c;
        issue_read.mem_req  = 1'b1;
        issue_read.mem_we   = 1'b0;
        issue_read.mem_byte = 1'b0;
        issue_read.mem_addr = addr;
    endfunction

    always_comb begin
        logic [15:0] base;
        base            = '0;
        nxt_s           = s_ff;
        nxt_s.wr_en     = 1'b0;
        nxt_s.resolved  = 1'b0;
        nxt_s.done      = 1'b0;
        nxt_s.wr_be     = operand_addr_pkg::BE_BOTH;
        case (s_ff.state)
            operand_addr_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_s.byte_op = instr[operand_addr_pkg::BYTE_BIT];
                    nxt_s.two_op  = two_op;
                    nxt_s.is_src  = two_op;
                    nxt_s.src_fld = instr[operand_addr_pkg::SRC_LSB +: 6];
                    nxt_s.dst_fld = instr[operand_addr_pkg::DST_LSB +: 6];
                    nxt_s.busy    = 1'b1;
                    nxt_s.state   = operand_addr_pkg::ST_RD;
                end
            end
            operand_addr_pkg::ST_RD: begin
                nxt_s.in_reg = 1'b0;
                nxt_s.state  = operand_addr_pkg::ST_EVAL;
            end
            operand_addr_pkg::ST_EVAL: begin
                nxt_s.ptr    = rf_rdata;
                nxt_s.wr_idx = cur_reg;
                nxt_s.state  = operand_addr_pkg::ST_OPDONE;
                case (cur_mode)
                    operand_addr_pkg::MODE_REG: begin
                        nxt_s.loc    = {13'h0000, cur_reg};
                        nxt_s.in_reg = 1'b1;
                    end
                    operand_addr_pkg::MODE_REG_DEF: begin
                        nxt_s.loc = rf_rdata;
                    end
                    operand_addr_pkg::MODE_AINC: begin
                        // Nothing is read here, so the step lands at once.
                        nxt_s.loc     = rf_rdata;
                        nxt_s.wr_en   = 1'b1;
                        nxt_s.wr_data = rf_rdata + step;
                    end
                    operand_addr_pkg::MODE_AINC_DEF: begin
                        nxt_s       = issue_read(nxt_s, rf_rdata);
                        nxt_s.state = operand_addr_pkg::ST_INDIR;
                    end
                    operand_addr_pkg::MODE_ADEC: begin
                        nxt_s.loc     = rf_rdata - step;
                        nxt_s.wr_en   = 1'b1;
                        nxt_s.wr_data = rf_rdata - step;
                    end
                    operand_addr_pkg::MODE_ADEC_DEF: begin
                        nxt_s.wr_en   = 1'b1;
                        nxt_s.wr_data = rf_rdata - operand_addr_pkg::WORD_STEP;
                        nxt_s         = issue_read(nxt_s, nxt_s.wr_data);
                        nxt_s.state   = operand_addr_pkg::ST_INDIR;
                    end
                    default: begin
                        // Index forms: the instruction pointer value is the fetch address, read here only for register 7.
                        if (cur_reg == operand_addr_pkg::IP_IDX) begin
                            nxt_s.ip_word = rf_rdata;
                            nxt_s         = issue_read(nxt_s, rf_rdata);
                            nxt_s.state   = operand_addr_pkg::ST_XFETCH;
                        end else begin
                            nxt_s.state = operand_addr_pkg::ST_RDPC;
                        end
                    end
                endcase
            end
            operand_addr_pkg::ST_RDPC: begin
                nxt_s.state = operand_addr_pkg::ST_PCV;
            end
            operand_addr_pkg::ST_PCV: begin
                nxt_s.ip_word = rf_rdata;
                nxt_s         = issue_read(nxt_s, rf_rdata);
                nxt_s.state   = operand_addr_pkg::ST_XFETCH;
            end
            operand_addr_pkg::ST_XFETCH: begin
                if (mem_ack) begin
                    nxt_s.mem_req = 1'b0;
                    nxt_s.wr_en   = 1'b1;
                    nxt_s.wr_idx  = operand_addr_pkg::IP_IDX;
                    nxt_s.wr_data = s_ff.ip_word + operand_addr_pkg::WORD_STEP;
                    // The base register is not written back unless it is register 7, which takes the advance.
                    base = (cur_reg == operand_addr_pkg::IP_IDX) ?
                           s_ff.ip_word + operand_addr_pkg::WORD_STEP : s_ff.ptr;
                    if (cur_mode == operand_addr_pkg::MODE_IDX) begin
                        nxt_s.loc   = base + mem_rdata;
                        nxt_s.state = operand_addr_pkg::ST_OPDONE;
                    end else begin
                        nxt_s = issue_read(nxt_s, base + mem_rdata);
                        nxt_s.state = operand_addr_pkg::ST_INDIR;
                    end
                end
            end
            operand_addr_pkg::ST_INDIR: begin
                if (mem_ack) begin
                    nxt_s.mem_req = 1'b0;
                    nxt_s.loc     = mem_rdata;
                    nxt_s.state   = operand_addr_pkg::ST_OPDONE;
                    if (cur_mode == operand_addr_pkg::MODE_AINC_DEF) begin
                        // Step only after the address word has been read.
                        nxt_s.wr_en   = 1'b1;
                        nxt_s.wr_data = s_ff.ptr + operand_addr_pkg::WORD_STEP;
                    end
                end
            end
            operand_addr_pkg::ST_OPDONE: begin
                if (s_ff.is_src) begin
                    nxt_s.src_loc    = s_ff.loc;
                    nxt_s.src_in_reg = s_ff.in_reg;
                    nxt_s.is_src     = 1'b0;
                    nxt_s.state      = operand_addr_pkg::ST_RD;
                end else begin
                    nxt_s.dst_loc    = s_ff.loc;
                    nxt_s.dst_in_reg = s_ff.in_reg;
                    nxt_s.resolved   = 1'b1;
                    nxt_s.state      = operand_addr_pkg::ST_WAITRES;
                end
            end
            operand_addr_pkg::ST_WAITRES: begin
                if (result_valid) begin
                    if (s_ff.dst_in_reg) begin
                        nxt_s.wr_en   = 1'b1;
                        nxt_s.wr_idx  = s_ff.dst_loc[2:0];
                        nxt_s.wr_data = result_data;
                        nxt_s.wr_be   = s_ff.byte_op ? operand_addr_pkg::BE_LOW :
                                        operand_addr_pkg::BE_BOTH;
                        nxt_s.state   = operand_addr_pkg::ST_FINISH;
                    end else begin
                        nxt_s.mem_req   = 1'b1;
                        nxt_s.mem_we    = 1'b1;
                        nxt_s.mem_byte  = s_ff.byte_op;
                        nxt_s.mem_addr  = s_ff.dst_loc;
                        nxt_s.mem_wdata = result_data;
                        nxt_s.state     = operand_addr_pkg::ST_WRRES;
                    end
                end
            end
            operand_addr_pkg::ST_WRRES: begin
                if (mem_ack) begin
                    nxt_s.mem_req = 1'b0;
                    nxt_s.mem_we  = 1'b0;
                    nxt_s.state   = operand_addr_pkg::ST_FINISH;
                end
            end
            operand_addr_pkg::ST_FINISH: begin
                nxt_s.done  = 1'b1;
                nxt_s.busy  = 1'b0;
                nxt_s.state = operand_addr_pkg::ST_IDLE;
            end
            default: begin
                nxt_s = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign busy       = s_ff.busy;
    assign resolved   = s_ff.resolved;
    assign src_loc    = s_ff.src_loc;
    assign src_in_reg = s_ff.src_in_reg;
    assign dst_loc    = s_ff.dst_loc;
    assign dst_in_reg = s_ff.dst_in_reg;
    assign byte_op    = s_ff.byte_op;
    assign done       = s_ff.done;
    assign mem_req    = s_ff.mem_req;
    assign mem_we     = s_ff.mem_we;
    assign mem_byte   = s_ff.mem_byte;
    assign mem_addr   = s_ff.mem_addr;
    assign mem_wdata  = s_ff.mem_wdata;

endmodule

// ===== operand_address_modes_assertions.sv
// Purpose: Port assertions for the operand address unit.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the unit.
module operand_address_modes_assertions (
    // Control
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        start,
    input wire logic        busy,
    input wire logic        resolved,
    input wire logic        done,
    input wire logic        byte_op,
    // Destination
    input wire logic [15:0] dst_loc,
    input wire logic        dst_in_reg,
    // Memory
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_byte,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic        mem_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_req_held: assert property (mem_req && !mem_ack |=> mem_req &&
        $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata)) else $error("request moved");
    a_idle_quiet: assert property (!busy && !done |-> !mem_req)
        else $error("request while idle");
    a_start_taken: assert property (start && !busy |=> busy)
        else $error("start not taken");
    a_resolve_quiet: assert property (resolved |-> busy && !mem_req)
        else $error("resolved with access open");
    a_write_dst: assert property (mem_req && mem_we |->
        mem_addr == dst_loc && !dst_in_reg) else $error("write away from destination");
    a_byte_write: assert property (mem_req && mem_byte |-> mem_we && byte_op)
        else $error("byte access not a byte write");
    a_reg_index: assert property (resolved && dst_in_reg |-> dst_loc[15:3] == 13'h0)
        else $error("register location out of range");
    a_done_once: assert property (done |=> !done && !resolved)
        else $error("done not a single pulse");
endmodule
bind operand_address_modes operand_address_modes_assertions chk_i (.*);

// ===== op_mem_model.sv
// Purpose: Memory seen by the operand address unit.
// Assumes: The word at each address is a fixed scramble of the address.
// Notes:   Writes are acked but not stored, a limitation the bench shares.
module op_mem_model (
    // Request
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic        slow,
    // Answer
    output logic            mem_ack,
    output logic [15:0]     mem_rdata
);
    logic [15:0] word;
    assign word = {mem_addr[7:0], mem_addr[15:8]} ^ 16'h3c5a;
    assign mem_ack = mem_req && !slow;
    // Outside an ack the bus shows the inverse, so a stale sample never matches.
    assign mem_rdata = (mem_ack && !mem_we) ? word : ~word;
endmodule

// ===== test_operand_address_modes.sv
// Purpose: Self-checking bench for the operand address unit.
// Assumes: Memory words follow the same address scramble as the model.
// Notes:   A reference register copy predicts every location and write.
module test_operand_address_modes;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic two; logic b; logic [16:0] s; logic [16:0] d;} loc_t;
    typedef struct packed {logic [16:0] a; logic [15:0] d;} wr_t;
    logic        clk, rstn, start, two_op, busy, resolved, src_in_reg, dst_in_reg, byte_op;
    logic        result_valid, done, load_en, mem_req, mem_we, mem_byte, mem_ack, slow;
    logic [2:0]  load_idx;
    logic [15:0] instr, src_loc, dst_loc, result_data, load_data, mem_addr, mem_wdata;
    logic [15:0] mem_rdata, f;
    logic [15:0] rg [8];
    loc_t        le;
    wr_t         wv;
    loc_t        lq [$];
    wr_t         wq [$];
    int          errors, n_tests, cycles, seed;
    operand_address_modes operand_address_modes_i (.*);
    op_mem_model op_mem_model_i (.*);
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] mf(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h3c5a;
    endfunction
    // Steps of one apply only to byte operations through registers 0 to 5.
    function automatic logic [16:0] res(input logic [5:0] fl, input logic bt);
        logic [2:0]  m;
        logic [2:0]  r;
        logic [15:0] x;
        logic [15:0] l;
        m = fl[5:3];
        r = fl[2:0];
        x = 16'h0;
        if (m >= 3'h6) begin
            x = mf(rg[7]);
            rg[7] += 16'h2;
        end
        case (m)
            3'h0: l = {13'h0, r};
            3'h1: l = rg[r];
            3'h2, 3'h3: begin
                l = rg[r];
                rg[r] += (bt && r < 3'h6 && m == 3'h2) ? 16'h1 : 16'h2;
            end
            3'h4, 3'h5: begin
                rg[r] -= (bt && r < 3'h6 && m == 3'h4) ? 16'h1 : 16'h2;
                l = rg[r];
            end
            default: l = x + rg[r];
        endcase
        if (m[0] && m != 3'h1) l = mf(l);
        return {m == 3'h0, l};
    endfunction
    task automatic run(input logic [15:0] ins, input logic two);
        loc_t        e;
        logic [15:0] d;
        d = 16'($random(seed));
        e.two = two;
        e.b = ins[15];
        e.s = 17'h0;
        if (two) e.s = res(ins[11:6], ins[15]);
        e.d = res(ins[5:0], ins[15]);
        lq.push_back(e);
        if (e.d[16]) rg[e.d[2:0]] = ins[15] ? {rg[e.d[2:0]][15:8], d[7:0]} : d;
        else wq.push_back({ins[15], e.d[15:0], ins[15] ? {8'h0, d[7:0]} : d});
        start = 1'b1;
        instr = ins;
        two_op = two;
        @(negedge clk);
        start = 1'b0;
        while (resolved !== 1'b1) @(negedge clk);
        result_valid = 1'b1;
        result_data = d;
        @(negedge clk);
        result_valid = 1'b0;
        while (done !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask
    task automatic probe();
        for (int r = 0; r < 8; r++) run({10'h0, 3'h1, r[2:0]}, 1'b0);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 20000) begin
                errors++;
                $display("ERROR timeout expected done seen hang");
                complete_run();
            end
        end
    end
    always @(negedge clk) slow <= 1'($random(seed));
    always @(posedge clk) begin
        if (resolved === 1'b1) begin
            le = lq.pop_front();
            chk("dst", {dst_in_reg, dst_loc}, le.d);
            chk("byte_op", {16'h0, byte_op}, {16'h0, le.b});
            if (le.two) chk("src", {src_in_reg, src_loc}, le.s);
        end
        if (mem_req === 1'b1 && mem_we === 1'b1 && mem_ack === 1'b1) begin
            wv = wq.pop_front();
            chk("wr_addr", {mem_byte, mem_addr}, wv.a);
            chk("wr_data", {1'b0, mem_wdata & (mem_byte ? 16'h00ff : 16'hffff)},
                {1'b0, wv.d});
        end
    end
    initial begin
        seed = 65;
        errors = 0;
        n_tests = 0;
        {rstn, start, two_op, result_valid, load_en, slow, load_idx} = 9'h0;
        {instr, result_data, load_data} = 48'h0;
        foreach (rg[i]) rg[i] = 16'h0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        probe();
        for (int i = 0; i < 8; i++) begin
            load_en = 1'b1;
            load_idx = i[2:0];
            load_data = 16'($random(seed));
            rg[i] = load_data;
            @(negedge clk);
        end
        load_en = 1'b0;
        for (int i = 0; i < 96; i++) begin
            f = 16'($random(seed));
            f[5:3] = i[2:0];
            if (i >= 80) f[2:0] = 3'h7;
            if (f[5:4] == 2'h2 && f[2:0] == 3'h7) f[2:0] = 3'h6;
            if (f[11:10] == 2'h2 && f[8:6] == 3'h7) f[8:6] = 3'h6;
            run(f, i[3]);
        end
        probe();
        rstn = 1'b0;
        foreach (rg[i]) rg[i] = 16'h0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        probe();
        complete_run();
    end
endmodule
